// File: tlp_pkg.sv
package tlp_pkg;

	localparam int unsigned TLP_ADDR_W  = 6;
	localparam int unsigned TLP_DUTY_W  = 11;

	localparam logic [5:0] TLP_GEN0_CONTROL   = 6'h20;
	localparam logic [5:0] TLP_GEN_CLK_CONFIG = 6'h21;
	localparam logic [5:0] TLP_GEN0_DUTY_HIGH = 6'h22;
	localparam logic [5:0] TLP_GEN0_DUTY_LOW  = 6'h23;
	localparam logic [5:0] TLP_BOUND_HIGH     = 6'h24;
	localparam logic [5:0] TLP_BOUND_LOW      = 6'h25;
	localparam logic [5:0] TLP_GEN1_CONTROL   = 6'h26;
	localparam logic [5:0] TLP_GEN1_DUTY_HIGH = 6'h28;
	localparam logic [5:0] TLP_GEN1_DUTY_LOW  = 6'h29;
	localparam logic [5:0] TLP_GEN2_CONTROL   = 6'h2c;
	localparam logic [5:0] TLP_GEN2_DUTY_HIGH = 6'h2e;
	localparam logic [5:0] TLP_GEN2_DUTY_LOW  = 6'h2f;

	// Control register fields
	localparam int unsigned TLP_CTL_STATUS_BIT = 6;
	localparam int unsigned TLP_CTL_INV_BIT    = 5;
	localparam int unsigned TLP_CTL_SEL_BIT    = 4;
	localparam int unsigned TLP_CTL_ROUTE_LSB  = 1;
	localparam int unsigned TLP_CTL_PRE_BIT    = 0;
	// Clock config fields
	localparam int unsigned TLP_CLK_EN_BIT     = 7;
	localparam int unsigned TLP_CLK_DIV_LSB    = 4;
	localparam int unsigned TLP_CLK_SRC_BIT    = 0;

	localparam logic [2:0] TLP_ROUTE_OFF = 3'h0;
	localparam logic [2:0] TLP_ROUTE_ONE = 3'h1;
	localparam logic [2:0] TLP_ROUTE_THR = 3'h3;
	localparam logic [2:0] TLP_ROUTE_FOU = 3'h4;
	localparam logic [2:0] TLP_ROUTE_FIV = 3'h5;

	localparam logic [7:0]  TLP_CTL_RESET  = 8'h00;
	localparam logic [7:0]  TLP_CLK_RESET  = 8'h00;
	localparam logic [10:0] TLP_DUTY_RESET = 11'h000;
	localparam logic [10:0] TLP_BOUND_RESET = 11'h7fe;
	localparam logic [2:0]  TLP_LOW_RESET  = 3'h0;

	typedef struct packed {
		logic        we;
		logic        re;
		logic [5:0]  addr;
		logic [7:0]  wdata;
	} tlp_io_req_type;

	typedef struct packed {
		logic port_b_bit5;
		logic port_a_bit0;
		logic port_b_bit4;
		logic port_b_bit6;
		logic port_a_bit4;
		logic port_b_bit7;
		logic port_b_bit3;
		logic port_a_bit3;
		logic port_b_bit2;
		logic port_a_bit5;
	} tlp_pins_type;

	typedef enum logic [1:0] {
		TLP_IDLE  = 2'b00,
		TLP_RUN   = 2'b01
	} tlp_state_type;

endpackage

// File: tlp_prescaler.sv
`timescale 1ns/1ps

module tlp_prescaler
	import tlp_pkg::*;
#(
	parameter int unsigned DIV_W = 7
)(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic       src_tick,
	input  wire logic [2:0] div_code,
	output logic            tick
);

	logic [DIV_W-1:0] cnt_q;
	logic [DIV_W-1:0] cnt_d;
	logic [DIV_W-1:0] limit;
	logic             wrap;

	// Divide by two to the power of the code
	assign limit = DIV_W'((8'h01 << div_code) - 8'h01);
	assign wrap  = src_tick && (cnt_q >= limit);
	assign cnt_d = !run ? '0 : (!src_tick ? cnt_q : (wrap ? '0 : cnt_q + 1'b1));
	assign tick  = run && wrap;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			cnt_q <= '0;
		else
			cnt_q <= cnt_d;
	end

endmodule // tlp_prescaler

// File: tlp_led_pwm.sv
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Operation
// - Generators run only while the global enable bit is set.
// - Prescaler code 0..7 divides generator clock by 1 through 128.
// - Source bit 0 selects system clock, 1 selects fast RC or double.
// - Duty is 11 bits: high byte bits 10..3, low byte 7..5 bits 2..0.
// - Bound high byte bits 10..3, low byte 7..6 bits 2..1, bit 0 fixed.
// - Control bit 6 reads back the generator's present output level.
// - Control bit 5 inverts that generator's output.
// - Generator a may output a xor b or a or b, chosen by bit 0.
// - Generator a routing: off, port B5, port A0, port B4.
// - Generator b path carries its own or generator c's waveform.
// - Generator b routing: off, port B6, port A4, port B7.
// - Generator c path may carry its waveform divided by two.
// - Generator c routing: off, port B3, A3, B2, A5.
module tlp_led_pwm
	import tlp_pkg::*;
#(
	parameter bit FAST_RC_DOUBLE = 1'b0
)(
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire logic           fast_rc_tick,
	input  wire logic           fast_rc_tick_x2,
	input  wire tlp_io_req_type io_req,
	output logic [7:0]          io_rdata,
	output logic                io_hit,
	output tlp_pins_type        pin_out,
	output tlp_pins_type        pin_oe
);

	//////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]            ctl_q [3];
	logic [7:0]            clk_cfg_q;
	logic [10:0]           duty_q [3];
	logic [2:0]            duty_low_q [3];
	logic [10:0]           bound_q;
	logic [10:0]           cnt_q;
	logic [10:0]           cnt_d;
	logic                  half_q;
	logic [2:0]            level_q;
	tlp_state_type         state_q;
	tlp_state_type         state_d;

	logic                  wr;
	logic                  enable;
	logic                  src_tick;
	logic                  tick;
	logic [2:0]            raw;
	logic [2:0]            path;
	logic [2:0]            level_d;
	logic [2:0]            route [3];
	logic                  wr_ctl  [3];
	logic                  wr_dh   [3];
	logic                  wr_dl   [3];

	function automatic logic [10:0] duty_join(input logic [7:0] hi, input logic [2:0] lo);
		return {hi, lo};
	endfunction

	//////////////////////////////////////////////////////////////////////////
	// Address decode

	assign wr = io_req.we;
	assign wr_ctl[0] = wr && (io_req.addr == TLP_GEN0_CONTROL);
	assign wr_ctl[1] = wr && (io_req.addr == TLP_GEN1_CONTROL);
	assign wr_ctl[2] = wr && (io_req.addr == TLP_GEN2_CONTROL);
	assign wr_dh[0]  = wr && (io_req.addr == TLP_GEN0_DUTY_HIGH);
	assign wr_dh[1]  = wr && (io_req.addr == TLP_GEN1_DUTY_HIGH);
	assign wr_dh[2]  = wr && (io_req.addr == TLP_GEN2_DUTY_HIGH);
	assign wr_dl[0]  = wr && (io_req.addr == TLP_GEN0_DUTY_LOW);
	assign wr_dl[1]  = wr && (io_req.addr == TLP_GEN1_DUTY_LOW);
	assign wr_dl[2]  = wr && (io_req.addr == TLP_GEN2_DUTY_LOW);

	assign io_hit = (io_req.addr >= TLP_GEN0_CONTROL) && (io_req.addr <= TLP_GEN2_DUTY_LOW);

	// Only control registers read back; write-only ones read zero
	always_comb
	begin
		io_rdata = 8'h00;
		case (io_req.addr)
			TLP_GEN0_CONTROL: io_rdata = {1'b0, level_q[0], ctl_q[0][5:0]};
			TLP_GEN1_CONTROL: io_rdata = {1'b0, level_q[1], ctl_q[1][5:0]};
			TLP_GEN2_CONTROL: io_rdata = {1'b0, level_q[2], ctl_q[2][5:0]};
			default:          io_rdata = 8'h00;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////
	// Register writes

	for (genvar g = 0; g < 3; g++)
	begin : g_gen_regs
		always_ff @(posedge core_clk)
		begin
			if (rst)
			begin
				ctl_q[g]      <= TLP_CTL_RESET;
				duty_q[g]     <= TLP_DUTY_RESET;
				duty_low_q[g] <= TLP_LOW_RESET;
			end
			else
			begin
				if (wr_ctl[g])
					ctl_q[g] <= {2'b00, io_req.wdata[5:0]};
				if (wr_dl[g])
					duty_low_q[g] <= io_req.wdata[7:5];
				if (wr_dh[g])
					duty_q[g] <= duty_join(io_req.wdata, duty_low_q[g]);
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			clk_cfg_q <= TLP_CLK_RESET;
			bound_q   <= TLP_BOUND_RESET;
		end
		else
		begin
			if (wr && (io_req.addr == TLP_GEN_CLK_CONFIG))
				clk_cfg_q <= {io_req.wdata[7:4], 3'h0, io_req.wdata[0]};
			if (wr && (io_req.addr == TLP_BOUND_HIGH))
				bound_q[10:3] <= io_req.wdata;
			if (wr && (io_req.addr == TLP_BOUND_LOW))
				bound_q[2:1] <= io_req.wdata[7:6];
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Clock source and prescaler

	assign enable = clk_cfg_q[TLP_CLK_EN_BIT];
	assign src_tick = !clk_cfg_q[TLP_CLK_SRC_BIT] ? 1'b1
		: (FAST_RC_DOUBLE ? fast_rc_tick_x2 : fast_rc_tick);

	tlp_prescaler #(
		.DIV_W    (7)
	) u_prescaler (
		.core_clk (core_clk),
		.rst      (rst),
		.run      (state_q == TLP_RUN),
		.src_tick (src_tick),
		.div_code (clk_cfg_q[TLP_CLK_DIV_LSB +: 3]),
		.tick     (tick)
	);

	//////////////////////////////////////////////////////////////////////////
	// Shared counter and comparators

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			TLP_IDLE: if (enable) state_d = TLP_RUN;
			TLP_RUN:  if (!enable) state_d = TLP_IDLE;
			default:  state_d = TLP_IDLE;
		endcase
	end

	assign cnt_d = (state_q != TLP_RUN) ? 11'h000
		: (!tick ? cnt_q : ((cnt_q >= bound_q) ? 11'h000 : cnt_q + 11'h001));

	for (genvar g = 0; g < 3; g++)
	begin : g_cmp
		assign raw[g] = (state_q == TLP_RUN) && (cnt_q < duty_q[g]);
	end

	// Path selection
	assign path[0] = !ctl_q[0][TLP_CTL_SEL_BIT] ? raw[0]
		: (ctl_q[0][TLP_CTL_PRE_BIT] ? (raw[0] | raw[1]) : (raw[0] ^ raw[1]));
	assign path[1] = ctl_q[1][TLP_CTL_SEL_BIT] ? raw[2] : raw[1];
	assign path[2] = ctl_q[2][TLP_CTL_SEL_BIT] ? half_q : raw[2];

	for (genvar g = 0; g < 3; g++)
	begin : g_inv
		assign level_d[g] = path[g] ^ ctl_q[g][TLP_CTL_INV_BIT];
		assign route[g]   = ctl_q[g][TLP_CTL_ROUTE_LSB +: 3];
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			state_q <= TLP_IDLE;
			cnt_q   <= 11'h000;
			half_q  <= 1'b0;
			level_q <= 3'h0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			if (state_q != TLP_RUN)
				half_q <= 1'b0;
			else if (tick && (cnt_q == 11'h000) && (duty_q[2] != 11'h000))
				half_q <= !half_q;
			level_q <= level_d;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Pin routing

	always_comb
	begin
		pin_oe = '0;
		pin_out = '0;
		case (route[0])
			TLP_ROUTE_ONE: pin_oe.port_b_bit5 = 1'b1;
			TLP_ROUTE_THR: pin_oe.port_a_bit0 = 1'b1;
			TLP_ROUTE_FOU: pin_oe.port_b_bit4 = 1'b1;
			default:       pin_oe.port_b_bit5 = 1'b0;
		endcase
		case (route[1])
			TLP_ROUTE_ONE: pin_oe.port_b_bit6 = 1'b1;
			TLP_ROUTE_THR: pin_oe.port_a_bit4 = 1'b1;
			TLP_ROUTE_FOU: pin_oe.port_b_bit7 = 1'b1;
			default:       pin_oe.port_b_bit6 = 1'b0;
		endcase
		case (route[2])
			TLP_ROUTE_ONE: pin_oe.port_b_bit3 = 1'b1;
			TLP_ROUTE_THR: pin_oe.port_a_bit3 = 1'b1;
			TLP_ROUTE_FOU: pin_oe.port_b_bit2 = 1'b1;
			TLP_ROUTE_FIV: pin_oe.port_a_bit5 = 1'b1;
			default:       pin_oe.port_b_bit3 = 1'b0;
		endcase
		pin_out.port_b_bit5 = pin_oe.port_b_bit5 & level_q[0];
		pin_out.port_a_bit0 = pin_oe.port_a_bit0 & level_q[0];
		pin_out.port_b_bit4 = pin_oe.port_b_bit4 & level_q[0];
		pin_out.port_b_bit6 = pin_oe.port_b_bit6 & level_q[1];
		pin_out.port_a_bit4 = pin_oe.port_a_bit4 & level_q[1];
		pin_out.port_b_bit7 = pin_oe.port_b_bit7 & level_q[1];
		pin_out.port_b_bit3 = pin_oe.port_b_bit3 & level_q[2];
		pin_out.port_a_bit3 = pin_oe.port_a_bit3 & level_q[2];
		pin_out.port_b_bit2 = pin_oe.port_b_bit2 & level_q[2];
		pin_out.port_a_bit5 = pin_oe.port_a_bit5 & level_q[2];
	end

endmodule // tlp_led_pwm

// File: tlp_properties.sv
`timescale 1ns/1ps

module tlp_properties
	import tlp_pkg::*;
(
	input  wire logic           core_clk,
	input  wire logic           rst,
	input  wire tlp_io_req_type io_req,
	input  wire logic [7:0]     io_rdata,
	input  wire logic           io_hit,
	input  wire tlp_pins_type   pin_out,
	input  wire tlp_pins_type   pin_oe
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic ctl = io_req.addr inside {TLP_GEN0_CONTROL, TLP_GEN1_CONTROL, TLP_GEN2_CONTROL};
	wire logic a0  = io_req.addr == TLP_GEN0_CONTROL;
	wire logic wr0 = io_req.we && a0;
	wire logic wr2 = io_req.we && io_req.addr == TLP_GEN2_CONTROL;

	hit_range_a: assert property (io_hit == (io_req.addr[5:4] == 2'h2)) else $error("hit flag wrong");
	wo_zero_a: assert property (!ctl |-> io_rdata == 8'h00) else $error("write-only read nonzero");
	ctl_top_a: assert property (ctl |-> !io_rdata[7]) else $error("control bit 7 set");
	pin_gate_a: assert property ((10'(pin_out) & ~10'(pin_oe)) == 10'h000) else $error("pin driven off");
	route_a_a: assert property (wr0 && io_req.wdata[3:1] == TLP_ROUTE_ONE |=> pin_oe.port_b_bit5 &&
		!pin_oe.port_a_bit0 && !pin_oe.port_b_bit4) else $error("gen a route wrong");
	route_c_a: assert property (wr2 && io_req.wdata[3:1] == TLP_ROUTE_FIV |=> pin_oe.port_a_bit5 &&
		!pin_oe.port_b_bit3 && !pin_oe.port_b_bit2) else $error("gen c route wrong");
	status_pin_a: assert property (a0 && pin_oe.port_b_bit5 |-> io_rdata[6] == pin_out.port_b_bit5)
		else $error("status mismatch");
	ctl_readback_a: assert property (wr0 |=> !a0 || io_rdata[5:0] == $past(io_req.wdata[5:0]))
		else $error("control readback wrong");
endmodule // tlp_properties

bind tlp_led_pwm tlp_properties chk (.core_clk(core_clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
	.io_hit(io_hit), .pin_out(pin_out), .pin_oe(pin_oe));

// File: tlp_pin_load.sv
`timescale 1ns/1ps

module tlp_pin_load
	import tlp_pkg::*;
(
	input  wire logic         core_clk,
	input  wire tlp_pins_type pin_out,
	input  wire tlp_pins_type pin_oe,
	output logic [9:0]        pad
);
	logic [9:0] last_q = 10'h000;
	// Undriven pad has no pull, shows a changing pattern
	assign pad = (10'(pin_out) & 10'(pin_oe)) | (~last_q & ~10'(pin_oe));
	always_ff @(posedge core_clk) last_q <= pad;
endmodule // tlp_pin_load

// File: testbench.sv
`timescale 1ns/1ps

module testbench
	import tlp_pkg::*;
;
	logic           core_clk = 1'b0;
	logic           rst = 1'b1;
	logic           fast_rc_tick = 1'b0;
	logic           fast_rc_tick_x2 = 1'b0;
	tlp_io_req_type io_req = '0;
	logic [7:0]     io_rdata;
	logic           io_hit;
	tlp_pins_type   pin_out;
	tlp_pins_type   pin_oe;
	logic [9:0]     pad;
	logic [1:0]     tk_q = 2'h0;
	int             n_errors = 0;
	int             compares = 0;

	tlp_led_pwm dut (.core_clk(core_clk), .rst(rst), .fast_rc_tick(fast_rc_tick), .fast_rc_tick_x2(fast_rc_tick_x2),
		.io_req(io_req), .io_rdata(io_rdata), .io_hit(io_hit), .pin_out(pin_out), .pin_oe(pin_oe));
	tlp_pin_load load (.core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe), .pad(pad));

	initial forever #2.5 core_clk = ~core_clk;
	// Fast RC tick every fourth cycle
	always @(posedge core_clk)
	begin
		tk_q <= tk_q + 2'h1;
		fast_rc_tick <= tk_q == 2'h3;
		fast_rc_tick_x2 <= tk_q[0];
	end

	//////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		$display("errors %0d compares %0d", n_errors, compares);
		if (n_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp)
		begin
			$display("unexpected %0t value %h not %h", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic chk_n(input int got, input int exp);
		compares++;
		if (got != exp)
		begin
			$display("unexpected %0t count %0d not %0d", $time, got, exp);
			n_errors++;
		end
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge core_clk);
		io_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
		@(posedge core_clk);
		io_req.we <= 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] exp, input logic hit);
		@(posedge core_clk);
		io_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
		#1;
		chk_v({8'h00, io_rdata}, {8'h00, exp});
		chk_v({15'h0, io_hit}, {15'h0, hit});
	endtask

	// Settle one window, then count high samples and rising edges
	task automatic meas(input int b, input int w, input int hi, input int rs);
		int h;
		int r;
		logic p;
		h = 0;
		r = 0;
		repeat (w) @(posedge core_clk);
		#1 p = pad[b];
		repeat (w)
		begin
			@(posedge core_clk);
			#1;
			h += (pad[b] === 1'b1);
			r += (pad[b] === 1'b1 && p === 1'b0);
			p = pad[b];
		end
		chk_n(h, hi);
		chk_n(r, rs);
	endtask

	function automatic logic [9:0] oe_exp(input int g, input int c);
		int base;
		base = 9 - 3 * g;
		oe_exp = '0;
		if (c == 1) oe_exp[base] = 1'b1;
		if (c == 3) oe_exp[base - 1] = 1'b1;
		if (c == 4) oe_exp[base - 2] = 1'b1;
		if (c == 5 && g == 2) oe_exp[0] = 1'b1;
	endfunction

	//////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [5:0] ctl [3];
		ctl = '{TLP_GEN0_CONTROL, TLP_GEN1_CONTROL, TLP_GEN2_CONTROL};
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		for (int g = 0; g < 3; g++) rd(ctl[g], 8'h00, 1'b1);
		wr(6'h27, 8'hff);
		rd(6'h27, 8'h00, 1'b1);
		rd(6'h10, 8'h00, 1'b0);
		wr(TLP_BOUND_HIGH, 8'h00);
		wr(TLP_BOUND_LOW, 8'hff);
		wr(TLP_GEN1_DUTY_LOW, 8'ha0);
		wr(TLP_GEN1_DUTY_HIGH, 8'h00);
		wr(TLP_GEN0_DUTY_LOW, 8'h7f);
		wr(TLP_GEN0_DUTY_HIGH, 8'h00);
		wr(TLP_GEN2_DUTY_LOW, 8'h20);
		wr(TLP_GEN2_DUTY_HIGH, 8'h00);
		wr(TLP_GEN0_CONTROL, 8'h02);
		wr(TLP_GEN_CLK_CONFIG, 8'h80);
		meas(9, 140, 60, 20);
		wr(TLP_GEN0_CONTROL, 8'h22);
		meas(9, 140, 80, 20);
		wr(TLP_GEN0_CONTROL, 8'h12);
		meas(9, 140, 40, 20);
		wr(TLP_GEN0_CONTROL, 8'h13);
		meas(9, 140, 100, 20);
		wr(TLP_GEN0_CONTROL, 8'h02);
		wr(TLP_GEN0_DUTY_LOW, 8'he0);
		meas(9, 140, 60, 20);
		wr(TLP_GEN0_DUTY_HIGH, 8'h00);
		meas(9, 140, 140, 0);
		rd(TLP_GEN0_CONTROL, 8'h42, 1'b1);
		wr(TLP_GEN1_CONTROL, 8'h12);
		meas(6, 140, 20, 20);
		wr(TLP_GEN2_CONTROL, 8'h12);
		meas(3, 140, 70, 10);
		wr(TLP_GEN0_DUTY_LOW, 8'h60);
		wr(TLP_GEN0_DUTY_HIGH, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			wr(TLP_GEN_CLK_CONFIG, 8'h80 | 8'(c << 4));
			meas(9, 14 << c, 6 << c, 2);
		end
		wr(TLP_GEN_CLK_CONFIG, 8'h81);
		meas(9, 56, 24, 2);
		wr(TLP_GEN_CLK_CONFIG, 8'h00);
		meas(9, 140, 0, 0);
		for (int g = 0; g < 3; g++) wr(ctl[g], 8'h00);
		for (int g = 0; g < 3; g++)
			for (int c = 0; c < 8; c++)
			begin
				wr(ctl[g], 8'(c << 1));
				// Control register lands at this edge; look once it has settled
				#1;
				chk_v({6'h0, 10'(pin_oe)}, {6'h0, oe_exp(g, c)});
			end
		end_of_test();
	end

	initial
	begin
		#150us;
		n_errors++;
		$display("unexpected %0t watchdog expired", $time);
		end_of_test();
	end
endmodule // testbench
